/* File: hdl/ds_clk_sel.sv */
// deep-sleep clock source select with break-before-make switching,
// clock verification fault latch with software clear, and interrupt logic
// assumes all inputs except RESET_N_I synchronous to CORE_CLK_I; the clock mux itself sits
// outside and obeys SYS_SRC_O only while SYS_GATE_O is low
`default_nettype none
// Function
// - override set and deep sleep: internal osc selected and powered, main osc off; here main osc stays on while a fault is pending
// - override clear: main oscillator stays system source, also in deep sleep
// - deep-sleep exit restores source and frequency held at entry; here the divider follows RUN_DIV_I from exit on
// - override acts only in deep sleep; run selection untouched
// - pending verification fault substitutes the known good internal clock
// - verify clear bit clears all latched verification faults together
// - clear bit keeps last written value; hardware never clears it
// - bits 31:1 reserved; read as zero here, software preserves them
module ds_clk_sel #(
	parameter int NFAULT = 2,
	parameter int DIV_W = 4
) (
	input wire logic CORE_CLK_I, // core clock
	input wire logic RESET_N_I, // async reset, active low
	input wire logic [11:0] REG_ADDR_I, // register byte address
	input wire logic [31:0] REG_WDATA_I, // write data
	input wire logic REG_WR_I, // write strobe
	input wire logic REG_RD_I, // read strobe
	output logic [31:0] REG_RDATA_O, // read data, cycle after strobe
	input wire logic DEEP_SLEEP_I, // high while deep sleep is in effect
	input wire logic RUN_SRC_I, // run-mode source, 1 internal
	input wire logic [DIV_W-1:0] RUN_DIV_I, // run-mode divider
	input wire logic [NFAULT-1:0] FAULT_EVT_I, // verification fault pulses
	output logic SYS_SRC_O, // system clock source, 1 internal
	output logic [DIV_W-1:0] SYS_DIV_O, // system clock divider
	output logic SYS_GATE_O, // system clock gate enable
	output logic DEEP_SLEEP_INTERNAL_OSC_OVERRIDE_PWR_O, // internal oscillator power
	output logic MOSC_PWR_O, // main oscillator power
	output logic FAULT_SUBST_O, // known good clock substituted
	output logic IRQ_O // level interrupt
);
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	// register file
	logic ovr_ff, nxt_ovr;
	logic vclr_ff, nxt_vclr;
	logic [ds_clk_pkg::IRQ_W-1:0] istat_ff, nxt_istat;
	logic [ds_clk_pkg::IRQ_W-1:0] imask_ff, nxt_imask;
	logic [31:0] rdata_ff, nxt_rdata;
	// fault latch and clock control
	logic [NFAULT-1:0] fault_ff, nxt_fault;
	logic ds_ff, nxt_ds;
	logic sav_src_ff, nxt_sav_src;
	logic [DIV_W-1:0] sav_div_ff, nxt_sav_div;
	ds_clk_pkg::sw_state_type st_ff, nxt_st;
	logic [7:0] cnt_ff, nxt_cnt;
	logic sel_ff, nxt_sel;
	logic tgt_ff, nxt_tgt;
	logic gate_ff, nxt_gate;
	logic mosc_ff, nxt_mosc;
	logic fault_any;
	logic target;
	logic [ds_clk_pkg::IRQ_W-1:0] ievt;

	assign fault_any = |fault_ff;

	always_comb begin
		if (fault_any) begin
			target = ds_clk_pkg::SRC_INT;
		end else if (ds_ff && ovr_ff) begin
			target = ds_clk_pkg::SRC_INT;
		end else if (ds_ff) begin
			target = ds_clk_pkg::SRC_MAIN;
		end else begin
			target = sav_src_ff;
		end
	end

	always_comb begin
		ievt = '0;
		ievt[ds_clk_pkg::IRQ_FAULT_BIT] = |FAULT_EVT_I;
		ievt[ds_clk_pkg::IRQ_ENTRY_BIT] = DEEP_SLEEP_I && !ds_ff;
		ievt[ds_clk_pkg::IRQ_EXIT_BIT] = !DEEP_SLEEP_I && ds_ff;
	end

	always_comb begin
		nxt_ovr = ovr_ff;
		nxt_vclr = vclr_ff;
		nxt_imask = imask_ff;
		nxt_istat = istat_ff;
		nxt_rdata = '0;
		if (REG_WR_I) begin
			if (hit(REG_ADDR_I, ds_clk_pkg::DS_CFG_OFF)) begin
				nxt_ovr = REG_WDATA_I[ds_clk_pkg::OVR_BIT];
			end
			if (hit(REG_ADDR_I, ds_clk_pkg::VFY_CLR_OFF)) begin
				nxt_vclr = REG_WDATA_I[ds_clk_pkg::VFY_CLR_BIT];
			end
			if (hit(REG_ADDR_I, ds_clk_pkg::IRQ_MASK_OFF)) begin
				nxt_imask = REG_WDATA_I[ds_clk_pkg::IRQ_W-1:0];
			end
			if (hit(REG_ADDR_I, ds_clk_pkg::IRQ_STAT_OFF)) begin
				nxt_istat = istat_ff & ~REG_WDATA_I[ds_clk_pkg::IRQ_W-1:0];
			end
		end
		// new events win over a same-cycle clear
		nxt_istat = nxt_istat | ievt;
		if (REG_RD_I) begin
			// reserved bits read as zero
			unique case (REG_ADDR_I)
				ds_clk_pkg::DS_CFG_OFF: nxt_rdata[ds_clk_pkg::OVR_BIT] = ovr_ff;
				ds_clk_pkg::VFY_CLR_OFF: nxt_rdata[ds_clk_pkg::VFY_CLR_BIT] = vclr_ff;
				ds_clk_pkg::FAULT_STAT_OFF: nxt_rdata[NFAULT-1:0] = fault_ff;
				ds_clk_pkg::IRQ_STAT_OFF: nxt_rdata[ds_clk_pkg::IRQ_W-1:0] = istat_ff;
				ds_clk_pkg::IRQ_MASK_OFF: nxt_rdata[ds_clk_pkg::IRQ_W-1:0] = imask_ff;
				ds_clk_pkg::CLK_STAT_OFF: nxt_rdata[3:0] = {mosc_ff, gate_ff, ds_ff, sel_ff};
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ovr_ff <= ds_clk_pkg::RST_OVR;
			vclr_ff <= ds_clk_pkg::RST_VFY_CLR;
			imask_ff <= ds_clk_pkg::RST_IRQ_MASK;
			istat_ff <= '0;
			rdata_ff <= '0;
		end else begin
			ovr_ff <= nxt_ovr;
			vclr_ff <= nxt_vclr;
			imask_ff <= nxt_imask;
			istat_ff <= nxt_istat;
			rdata_ff <= nxt_rdata;
		end
	end

	always_comb begin
		// events arriving while clear is held show in fault_ff for one cycle only
		nxt_fault = (vclr_ff ? '0 : fault_ff) | FAULT_EVT_I;
		nxt_ds = DEEP_SLEEP_I;
		nxt_sav_src = sav_src_ff;
		nxt_sav_div = sav_div_ff;
		if (!DEEP_SLEEP_I && !ds_ff) begin
			// track run setting; frozen from deep-sleep entry until exit
			nxt_sav_src = RUN_SRC_I;
			nxt_sav_div = RUN_DIV_I;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			fault_ff <= '0;
			ds_ff <= 1'b0;
			sav_src_ff <= ds_clk_pkg::SRC_MAIN;
			sav_div_ff <= '0;
		end else begin
			fault_ff <= nxt_fault;
			ds_ff <= nxt_ds;
			sav_src_ff <= nxt_sav_src;
			sav_div_ff <= nxt_sav_div;
		end
	end

	// break-before-make switch sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sel = sel_ff;
		nxt_tgt = tgt_ff;
		nxt_gate = gate_ff;
		unique case (st_ff)
			ds_clk_pkg::ST_STEADY: begin
				if (target != sel_ff) begin
					nxt_tgt = target;
					nxt_gate = 1'b0;
					nxt_cnt = ds_clk_pkg::SW_GAP_CYC;
					nxt_st = ds_clk_pkg::ST_GATE_OFF;
				end
			end
			ds_clk_pkg::ST_GATE_OFF: begin
				if (cnt_ff != 8'h00) begin
					nxt_cnt = cnt_ff - 8'h01;
				end else begin
					nxt_sel = tgt_ff;
					nxt_cnt = ds_clk_pkg::SW_GAP_CYC;
					nxt_st = ds_clk_pkg::ST_SWAP;
				end
			end
			ds_clk_pkg::ST_SWAP: begin
				if (cnt_ff != 8'h00) begin
					nxt_cnt = cnt_ff - 8'h01;
				end else begin
					nxt_gate = 1'b1;
					nxt_st = ds_clk_pkg::ST_STEADY;
				end
			end
			default: begin
				nxt_gate = 1'b0;
				nxt_st = ds_clk_pkg::ST_STEADY;
			end
		endcase
		// main osc off only once running from internal in deep sleep
		nxt_mosc = !(ds_ff && ovr_ff && !fault_any && nxt_sel == ds_clk_pkg::SRC_INT
			&& target == ds_clk_pkg::SRC_INT);
	end

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_ff <= ds_clk_pkg::ST_STEADY;
			cnt_ff <= '0;
			sel_ff <= ds_clk_pkg::SRC_MAIN;
			tgt_ff <= ds_clk_pkg::SRC_MAIN;
			gate_ff <= 1'b1;
			mosc_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sel_ff <= nxt_sel;
			tgt_ff <= nxt_tgt;
			gate_ff <= nxt_gate;
			mosc_ff <= nxt_mosc;
		end
	end

	assign REG_RDATA_O = rdata_ff;
	assign SYS_SRC_O = sel_ff;
	assign SYS_DIV_O = ds_ff ? sav_div_ff : RUN_DIV_I;
	assign SYS_GATE_O = gate_ff;
	assign MOSC_PWR_O = mosc_ff;
	assign DEEP_SLEEP_INTERNAL_OSC_OVERRIDE_PWR_O = (sel_ff == ds_clk_pkg::SRC_INT) || (target == ds_clk_pkg::SRC_INT);
	assign FAULT_SUBST_O = fault_any;
	assign IRQ_O = |(istat_ff & imask_ff);

	// checks
	logic steady_ok;
	assign steady_ok = (st_ff == ds_clk_pkg::ST_STEADY) && gate_ff;

	sequence s_gate_low2;
		!gate_ff ##1 !gate_ff;
	endsequence

	// edges from gate fall to swap, and from swap to gate reopen
	localparam int GAP_EDGES = int'(ds_clk_pkg::SW_GAP_CYC) + 1;

	sequence s_swap_due;
		##GAP_EDGES $changed(sel_ff);
	endsequence

	sequence s_reopen_due;
		##GAP_EDGES $rose(gate_ff);
	endsequence

	AST_OVR_SLEEP_INT: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$rose(ds_ff) && ovr_ff && !fault_any && !REG_WR_I
		|-> ##[1:30] (SYS_SRC_O && DEEP_SLEEP_INTERNAL_OSC_OVERRIDE_PWR_O && !MOSC_PWR_O))
		else $error("override sleep did not move to internal osc");
	AST_NO_OVR_MAIN: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		steady_ok && $past(steady_ok) && $past(ds_ff)
		&& !$past(ovr_ff) && !$past(fault_any)
		|-> SYS_SRC_O == ds_clk_pkg::SRC_MAIN)
		else $error("main osc not kept in deep sleep");
	AST_EXIT_RESTORE: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$fell(ds_ff) && !fault_any ##1 !fault_any [*2]
		|-> ##[0:30] (steady_ok && SYS_SRC_O == sav_src_ff))
		else $error("source not restored on exit");
	AST_RUN_TRACK: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		!DEEP_SLEEP_I && !ds_ff |=> sav_src_ff == $past(RUN_SRC_I))
		else $error("run selection not followed");
	AST_FAULT_SUBST: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		steady_ok && $past(steady_ok) && fault_any && $past(fault_any)
		|-> SYS_SRC_O == ds_clk_pkg::SRC_INT && FAULT_SUBST_O)
		else $error("no substitute clock during fault");
	AST_CLEAR_ALL: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		vclr_ff && FAULT_EVT_I == '0 |=> fault_ff == '0)
		else $error("verify clear left a fault latched");
	AST_CLR_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		!(REG_WR_I && hit(REG_ADDR_I, ds_clk_pkg::VFY_CLR_OFF)) |=> $stable(vclr_ff))
		else $error("clear bit changed without a write");
	AST_RSVD_ZERO: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		REG_RD_I && (hit(REG_ADDR_I, ds_clk_pkg::DS_CFG_OFF)
		|| hit(REG_ADDR_I, ds_clk_pkg::VFY_CLR_OFF)) |=> REG_RDATA_O[31:1] == 31'h0)
		else $error("reserved bits not zero");
	AST_GLITCH_FREE: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$changed(sel_ff) |-> !$past(gate_ff) ##0 s_gate_low2)
		else $error("source swapped with gate open");
	AST_GATE_GAP: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$fell(gate_ff) |-> !gate_ff [*8])
		else $error("gate reopened too soon");

	// switch timing, oscillator power, sleep divider hold and fault latch
	AST_SWITCH_TIMING: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$fell(gate_ff) |-> s_swap_due ##0 s_reopen_due)
		else $error("switch steps out of time");
	AST_MAIN_POWERED: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		SYS_SRC_O == ds_clk_pkg::SRC_MAIN |-> MOSC_PWR_O)
		else $error("main osc selected while powered down");
	AST_EXIT_MAIN_UP: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$fell(ds_ff) |=> MOSC_PWR_O)
		else $error("main osc not powered after exit");
	AST_SLEEP_DIV_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		ds_ff && $past(ds_ff) |-> $stable(SYS_DIV_O))
		else $error("divider moved during deep sleep");
	AST_FAULT_LATCH: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		FAULT_EVT_I != '0 |=> FAULT_SUBST_O)
		else $error("fault event not latched");
endmodule : ds_clk_sel
`default_nettype wire

/* File: inc/ds_clk_pkg.sv */
// constants for the deep-sleep clock select and clock verify clear block
// assumes a 12-bit byte address register port and a 10 MHz core clock
`default_nettype none
package ds_clk_pkg;
	localparam logic [11:0] DS_CFG_OFF = 12'h0144;
	localparam logic [11:0] VFY_CLR_OFF = 12'h0150;
	localparam logic [11:0] FAULT_STAT_OFF = 12'h0158;
	localparam logic [11:0] IRQ_STAT_OFF = 12'h0170;
	localparam logic [11:0] IRQ_MASK_OFF = 12'h0174;
	localparam logic [11:0] CLK_STAT_OFF = 12'h0178;
	localparam int OVR_BIT = 0;
	localparam int VFY_CLR_BIT = 0;
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_ENTRY_BIT = 1;
	localparam int IRQ_EXIT_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic RST_OVR = 1'b0;
	localparam logic RST_VFY_CLR = 1'b0;
	localparam logic [2:0] RST_IRQ_MASK = 3'h0;
	localparam logic SRC_MAIN = 1'b0;
	localparam logic SRC_INT = 1'b1;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SW_GAP_NS = 1000;
	localparam int SW_GAP_CYC_I = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SW_GAP_CYC = 8'(SW_GAP_CYC_I);
	typedef enum logic [1:0] {
		ST_STEADY = 2'b00,
		ST_GATE_OFF = 2'b01,
		ST_SWAP = 2'b10
	} sw_state_type;
endpackage : ds_clk_pkg
`default_nettype wire

/* File: tb/deep_sleep_clock_select_test.sv */
// self-checking bench for the deep-sleep clock select block
// assumes the register map and switch timing of ds_clk_pkg, one 10 MHz clock
`default_nettype none
module deep_sleep_clock_select_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ds = 1'b0;
	logic run_src = 1'b0;
	logic [3:0] run_div = 4'h0;
	logic [1:0] fevt = 2'h0;
	logic [31:0] rdata;
	logic src, gate, deep_sleep_internal_osc_override, mosc, subst, irq;
	logic [3:0] div;
	logic [3:0] d0;
	logic [31:0] rng = 32'h0000_97d6;
	logic [31:0] exp_q[$];
	logic rd_q = 1'b0;
	logic src_q = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	ds_clk_sel #(.NFAULT(2), .DIV_W(4)) i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .DEEP_SLEEP_I(ds), .RUN_SRC_I(run_src), .RUN_DIV_I(run_div),
		.FAULT_EVT_I(fevt), .SYS_SRC_O(src), .SYS_DIV_O(div), .SYS_GATE_O(gate),
		.DEEP_SLEEP_INTERNAL_OSC_OVERRIDE_PWR_O(deep_sleep_internal_osc_override), .MOSC_PWR_O(mosc), .FAULT_SUBST_O(subst), .IRQ_O(irq));
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// the expected word is queued; the watcher below compares it
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	task automatic pins(input logic [3:0] e);
		check("mosc deep_sleep_internal_osc_override gate src", {28'h0, mosc, deep_sleep_internal_osc_override, gate, src}, {28'h0, e});
	endtask : pins
	// waits until the source is v with the gate open again
	task automatic settle(input logic v);
		int n;
		n = 0;
		while (!(src === v && gate === 1'b1 && n > 4) && n < 80) begin
			@(posedge clk);
			n++;
		end
		check("source", {31'h0, src}, {31'h0, v});
	endtask : settle
	task automatic pulse(input logic [1:0] f);
		@(posedge clk);
		fevt <= f;
		@(posedge clk);
		fevt <= 2'h0;
	endtask : pulse
	always @(posedge clk) begin
		rd_q <= rd;
		src_q <= src;
		if (rd_q === 1'b1) begin
			check("read data", rdata, exp_q.pop_front());
		end
		if (rst_n === 1'b1 && src !== src_q) begin
			check("gate at swap", {31'h0, gate}, 32'h0);
		end
	end
	initial begin
		#(100 * 5000);
		n_errors++;
		$display("watchdog expired");
		test_done();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		run_div <= 4'(xs());
		@(posedge clk);
		pins(4'b1010);
		rd_reg(ds_clk_pkg::DS_CFG_OFF, 32'h0);
		rd_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h0);
		rd_reg(ds_clk_pkg::IRQ_MASK_OFF, 32'h0);
		rd_reg(12'h200, 32'h0);
		wr_reg(ds_clk_pkg::DS_CFG_OFF, 32'h1);
		rd_reg(ds_clk_pkg::DS_CFG_OFF, 32'h1);
		repeat (30) @(posedge clk);
		pins(4'b1010);
		$display("reset and run test done");
		d0 = run_div;
		ds <= 1'b1;
		settle(1'b1);
		pins(4'b0111);
		rd_reg(ds_clk_pkg::CLK_STAT_OFF, 32'h7);
		run_div <= ~d0;
		repeat (3) @(posedge clk);
		check("divider in sleep", {28'h0, div}, {28'h0, d0});
		run_div <= d0;
		ds <= 1'b0;
		settle(1'b0);
		pins(4'b1010);
		check("divider after exit", {28'h0, div}, {28'h0, d0});
		wr_reg(ds_clk_pkg::DS_CFG_OFF, 32'h0);
		run_src <= 1'b1;
		settle(1'b1);
		ds <= 1'b1;
		settle(1'b0);
		repeat (4) @(posedge clk);
		ds <= 1'b0;
		settle(1'b1);
		run_src <= 1'b0;
		settle(1'b0);
		$display("sleep test done");
		rd_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h6);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr_reg(ds_clk_pkg::IRQ_MASK_OFF, 32'h7);
		@(posedge clk);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		wr_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h6);
		rd_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h0);
		check("irq cleared", {31'h0, irq}, 32'h0);
		$display("interrupt test done");
		pulse(2'h3);
		settle(1'b1);
		check("substitute", {31'h0, subst}, 32'h1);
		rd_reg(ds_clk_pkg::FAULT_STAT_OFF, 32'h3);
		rd_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h1);
		check("irq fault", {31'h0, irq}, 32'h1);
		wr_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h1);
		rd_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h1);
		rd_reg(ds_clk_pkg::FAULT_STAT_OFF, 32'h0);
		repeat (5) @(posedge clk);
		rd_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h1);
		wr_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h0);
		pulse(2'h1);
		rd_reg(ds_clk_pkg::FAULT_STAT_OFF, 32'h1);
		wr_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h1);
		wr_reg(ds_clk_pkg::VFY_CLR_OFF, 32'h0);
		rd_reg(ds_clk_pkg::FAULT_STAT_OFF, 32'h0);
		wr_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h1);
		rd_reg(ds_clk_pkg::IRQ_STAT_OFF, 32'h0);
		settle(1'b0);
		check("substitute off", {31'h0, subst}, 32'h0);
		$display("fault test done");
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule : deep_sleep_clock_select_test
`default_nettype wire
